// ==== rtl/rx_port_video_monitor_map.svh ====
// Register offsets, field positions, reset values and timing counts
// What this block does
// RULE1: Line length is reported as high and low bytes and holds the length of the last line of the latest frame.
// RULE2: With the line length change interrupt enabled, a published length stays frozen until the host reads it.
// RULE3: Reading the high byte captures the low byte so the following low byte read matches it; host reads high first.
// RULE4: The held clock frequency is replaced only when a measurement differs from it by more than the hysteresis in MHz, reset 3.
// RULE5: The clock is declared stable after staying in the hysteresis range for 40us, 80us, 320us or 1.28ms, default 40us.
// RULE6: No forward clock status is 1 while the measured frequency is below a 4-bit low threshold in MHz, reset 5.
// RULE7: Two 8-bit mailbox bytes are read/write with no side effect and reset to 0x00 and 0x01.
// RULE8: Packet length error bit 3 sets when a long packet header word count differs from the received payload length.
// RULE9: Checksum error bit 2 sets when a long packet payload checksum mismatches.
// RULE10: Multi-bit ECC error bit 1 sets on an uncorrectable header and that header passes uncorrected.
// RULE11: Single-bit header ECC errors are corrected and set ECC bit 0.
// RULE12: Packet error bits are sticky and clear when the host reads the status register.
// RULE13: Each receive port has its own copy of these registers, chosen by the port select.
// RULE14: Status bits 7:4 read as zero and ignore writes.
`ifndef RX_PORT_VIDEO_MONITOR_MAP_SVH
`define RX_PORT_VIDEO_MONITOR_MAP_SVH

`define NUM_RX_PORTS        4
`define ADDR_LINE_LEN_HIGH  8'h75
`define ADDR_LINE_LEN_LOW   8'h76
`define ADDR_FREQ_CTL       8'h77
`define ADDR_MAILBOX_A      8'h78
`define ADDR_MAILBOX_B      8'h79
`define ADDR_PKT_ERR        8'h7A

`define FREQ_CTL_RESET      8'hC5
`define MAILBOX_A_RESET     8'h00
`define MAILBOX_B_RESET     8'h01
`define PKT_ERR_RESET       4'h0

`define HYST_MSB            7
`define HYST_LSB            6
`define STABLE_MSB          5
`define STABLE_LSB          4
`define LOW_THR_MSB         3
`define LOW_THR_LSB         0

`define ERR_LENGTH_BIT      3
`define ERR_CHECKSUM_BIT    2
`define ERR_MULTI_ECC_BIT   1
`define ERR_SINGLE_ECC_BIT  0

`define CORE_CLK_PERIOD_NS  100
`define STABLE_T0_NS        40000
`define STABLE_T1_NS        80000
`define STABLE_T2_NS        320000
`define STABLE_T3_NS        1280000
`define NS_TO_CYCLES(ns) \
  (((ns) + `CORE_CLK_PERIOD_NS - 1) / `CORE_CLK_PERIOD_NS)
`define STABLE_T0_CYCLES    `NS_TO_CYCLES(`STABLE_T0_NS)
`define STABLE_T1_CYCLES    `NS_TO_CYCLES(`STABLE_T1_NS)
`define STABLE_T2_CYCLES    `NS_TO_CYCLES(`STABLE_T2_NS)
`define STABLE_T3_CYCLES    `NS_TO_CYCLES(`STABLE_T3_NS)

`define CSI_LONG_DT_MIN     6'h10
`define ECC_MASK_P0         24'hF12CB7
`define ECC_MASK_P1         24'hF2555B
`define ECC_MASK_P2         24'h749A6D
`define ECC_MASK_P3         24'hB8E38E
`define ECC_MASK_P4         24'hDF03F0
`define ECC_MASK_P5         24'hEFFC00

`endif

// ==== rtl/rx_port_video_monitor_pkg.sv ====
// Types shared by the receive port monitor and its header corrector
`default_nettype none
package rx_port_video_monitor_pkg;

  typedef struct packed {
    logic        line_end;
    logic [15:0] line_length;
    logic        frame_end;
    logic        freq_valid;
    logic [7:0]  freq_mhz;
    logic        hdr_valid;
    logic [23:0] hdr_data;
    logic [5:0]  hdr_ecc;
    logic        pkt_end;
    logic [15:0] pkt_bytes;
    logic [15:0] crc_calc;
    logic [15:0] crc_rx;
  } video_in_s;

  typedef struct packed {
    logic        valid;
    logic [23:0] data;
    logic        single;
    logic        multi;
  } hdr_out_s;

  typedef struct packed {
    logic [15:0] line_work;
    logic [15:0] line_len;
    logic [7:0]  low_shadow;
    logic        frozen;
    logic [7:0]  freq_ctl;
    logic [7:0]  mailbox_a;
    logic [7:0]  mailbox_b;
    logic [3:0]  pkt_err;
    logic [15:0] word_count;
    logic        long_pkt;
    logic [7:0]  freq_held;
    logic [13:0] stable_cnt;
    logic        stable;
    logic        no_clk;
  } port_state_s;

  typedef port_state_s [3:0] port_array_t;

  typedef struct packed {
    port_array_t port;
    logic [7:0]  rdata;
  } monitor_state_s;

endpackage
`default_nettype wire

// ==== rtl/header_ecc_corrector.sv ====
// Packet header ECC check and single-bit correction for one port
`include "rx_port_video_monitor_map.svh"
`default_nettype none
module header_ecc_corrector
  import rx_port_video_monitor_pkg::*;
(
  input  wire logic        clk,       // Core clock
  input  wire logic        reset_n,   // Async reset, active low
  input  wire logic        hdr_valid, // Header strobe
  input  wire logic [23:0] hdr_data,  // Header data bits
  input  wire logic [5:0]  hdr_ecc,   // Received ECC byte
  output hdr_out_s         result     // Registered result
);

  localparam logic [23:0] MASKS [6] = '{`ECC_MASK_P0, `ECC_MASK_P1,
    `ECC_MASK_P2, `ECC_MASK_P3, `ECC_MASK_P4, `ECC_MASK_P5};

  hdr_out_s st_q;
  hdr_out_s st_d;

  // Syndrome column of one data bit
  function automatic logic [5:0] column(input int unsigned bit_idx);
    logic [5:0] c;
    c = 6'h00;
    for (int k = 0; k < 6; k++) begin
      c[k] = MASKS[k][bit_idx];
    end
    return c;
  endfunction

  logic [5:0] syndrome;
  logic       flipped;

  always_comb begin
    flipped = 1'b0;
    for (int k = 0; k < 6; k++) begin
      syndrome[k] = ^(hdr_data & MASKS[k]) ^ hdr_ecc[k];
    end
    st_d        = '0;
    st_d.valid  = hdr_valid;
    st_d.data   = hdr_data;
    for (int i = 0; i < 24; i++) begin
      if (syndrome != 6'h00 && syndrome == column(i)) begin
        st_d.data[i] = ~hdr_data[i]; // see RULE11
        flipped      = 1'b1;
      end
    end
    // One set syndrome bit means the ECC byte itself was hit
    if (syndrome != 6'h00) begin
      if (flipped || $onehot(syndrome)) begin
        st_d.single = hdr_valid; // see RULE11
      end else begin
        st_d.multi  = hdr_valid; // see RULE10
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign result = st_q;

endmodule
`default_nettype wire

// ==== rtl/rx_port_video_monitor.sv ====
// Per-port line length, clock frequency, mailbox and packet error bank
`include "rx_port_video_monitor_map.svh"
`default_nettype none
module rx_port_video_monitor
  import rx_port_video_monitor_pkg::*;
#(
  parameter logic [13:0] STABLE_LONG_CYCLES = 14'(`STABLE_T3_CYCLES)
)
(
  input  wire logic                  CORE_CLK,     // Core clock, 10 MHz
  input  wire logic                  RESET_N,      // Async reset, low
  input  wire logic [1:0]            PORT_SEL,     // Selected rx port
  input  wire logic [7:0]            REG_ADDR,     // Register offset
  input  wire logic [7:0]            REG_WDATA,    // Write data
  input  wire logic                  REG_WR,       // Write strobe
  input  wire logic                  REG_RD,       // Read strobe
  output logic [7:0]                 REG_RDATA,    // Read data
  input  wire logic [3:0]            LINE_LENGTH_CHANGE_IRQ_ENABLE, // Per port
  input  wire rx_port_video_monitor_pkg::video_in_s [3:0] VIDEO_IN, // Link
  output rx_port_video_monitor_pkg::hdr_out_s  [3:0] HDR_OUT,  // Headers
  output logic [3:0]                 FREQ_STABLE,  // Clock stable
  output logic [3:0]                 NO_FORWARD_CLOCK_STATUS // Clock low
);

  import rx_port_video_monitor_pkg::*;

  monitor_state_s q;
  monitor_state_s d;
  hdr_out_s [3:0] ecc_res;

  // Header correction sits in the port path so flags and word count
  // both see the corrected header one cycle after its strobe.
  generate
    for (genvar g = 0; g < `NUM_RX_PORTS; g++) begin : g_ecc
      header_ecc_corrector u_ecc (
        .clk       (CORE_CLK),
        .reset_n   (RESET_N),
        .hdr_valid (VIDEO_IN[g].hdr_valid),
        .hdr_data  (VIDEO_IN[g].hdr_data),
        .hdr_ecc   (VIDEO_IN[g].hdr_ecc),
        .result    (ecc_res[g])
      );
    end
  endgenerate

  // Dwell time in core cycles for a stable time code
  function automatic logic [13:0] stable_limit(input logic [1:0] code);
    unique case (code)
      2'h0:    return 14'(`STABLE_T0_CYCLES);
      2'h1:    return 14'(`STABLE_T1_CYCLES);
      2'h2:    return 14'(`STABLE_T2_CYCLES);
      default: return STABLE_LONG_CYCLES;
    endcase
  endfunction

  // Register read view of one port
  function automatic logic [7:0] read_view(input port_state_s s,
                                           input logic [7:0]  a);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      `ADDR_LINE_LEN_HIGH: v = s.line_len[15:8];  // see RULE1
      `ADDR_LINE_LEN_LOW:  v = s.low_shadow;      // see RULE3
      `ADDR_FREQ_CTL:      v = s.freq_ctl;
      `ADDR_MAILBOX_A:     v = s.mailbox_a;       // see RULE7
      `ADDR_MAILBOX_B:     v = s.mailbox_b;       // see RULE7
      `ADDR_PKT_ERR:       v = {4'h0, s.pkt_err}; // see RULE14
      default:             v = 8'h00;
    endcase
    return v;
  endfunction

  logic [3:0]  sel;
  logic [3:0]  rd_hit;
  logic [7:0]  diff;
  logic [1:0]  hyst;
  logic [3:0]  set_err;
  logic [13:0] limit;

  always_comb begin
    d      = q;
    sel    = 4'h0;
    rd_hit = 4'h0;
    diff   = 8'h00;
    hyst   = 2'h0;
    set_err = 4'h0;
    limit  = 14'h0000;
    for (int p = 0; p < `NUM_RX_PORTS; p++) begin
      sel[p] = (PORT_SEL == 2'(p)); // see RULE13
      rd_hit[p] = REG_RD && sel[p];

      // Line length tracking; the latest line wins so a frame whose
      // line length drifts reports its last line.
      if (VIDEO_IN[p].line_end) begin
        d.port[p].line_work = VIDEO_IN[p].line_length; // see RULE1
      end
      if (rd_hit[p] && REG_ADDR == `ADDR_LINE_LEN_HIGH) begin
        d.port[p].low_shadow = q.port[p].line_len[7:0]; // see RULE3
        d.port[p].frozen     = 1'b0;                   // see RULE2
      end
      if (VIDEO_IN[p].frame_end && !q.port[p].frozen) begin // see RULE2
        d.port[p].line_len = VIDEO_IN[p].line_end ?
                             VIDEO_IN[p].line_length :
                             q.port[p].line_work;       // see RULE1
        d.port[p].frozen   = LINE_LENGTH_CHANGE_IRQ_ENABLE[p];
      end

      // Frequency detector: the dwell counter runs each cycle until stable is set,
      // and only a measurement outside the hysteresis band restarts it.
      hyst  = q.port[p].freq_ctl[`HYST_MSB:`HYST_LSB];
      limit = stable_limit(q.port[p].freq_ctl[`STABLE_MSB:`STABLE_LSB]);
      if (!q.port[p].stable) begin
        if (q.port[p].stable_cnt >= limit - 14'h0001) begin
          d.port[p].stable = 1'b1; // see RULE5
        end else begin
          d.port[p].stable_cnt = q.port[p].stable_cnt + 14'h0001;
        end
      end
      if (VIDEO_IN[p].freq_valid) begin
        diff = (VIDEO_IN[p].freq_mhz > q.port[p].freq_held) ?
               VIDEO_IN[p].freq_mhz - q.port[p].freq_held :
               q.port[p].freq_held - VIDEO_IN[p].freq_mhz;
        d.port[p].no_clk = VIDEO_IN[p].freq_mhz <
          {4'h0, q.port[p].freq_ctl[`LOW_THR_MSB:`LOW_THR_LSB]}; // see RULE6
        if (diff > {6'h00, hyst}) begin // see RULE4
          d.port[p].freq_held  = VIDEO_IN[p].freq_mhz;
          d.port[p].stable_cnt = 14'h0000;
          d.port[p].stable     = 1'b0;  // see RULE5
        end
      end

      // Packet checks use the header as corrected; a header left
      // uncorrected does not overwrite the expected word count.
      if (ecc_res[p].valid && !ecc_res[p].multi) begin
        d.port[p].word_count = ecc_res[p].data[23:8];
        d.port[p].long_pkt   = ecc_res[p].data[5:0] >= `CSI_LONG_DT_MIN;
      end
      set_err = 4'h0;
      set_err[`ERR_LENGTH_BIT] = VIDEO_IN[p].pkt_end && q.port[p].long_pkt &&
        (VIDEO_IN[p].pkt_bytes != q.port[p].word_count); // see RULE8
      set_err[`ERR_CHECKSUM_BIT] = VIDEO_IN[p].pkt_end &&
        q.port[p].long_pkt &&
        (VIDEO_IN[p].crc_calc != VIDEO_IN[p].crc_rx);    // see RULE9
      set_err[`ERR_MULTI_ECC_BIT]  = ecc_res[p].multi;   // see RULE10
      set_err[`ERR_SINGLE_ECC_BIT] = ecc_res[p].single;  // see RULE11
      // New errors win over a clear-on-read in the same cycle
      d.port[p].pkt_err = ((rd_hit[p] && REG_ADDR == `ADDR_PKT_ERR) ?
                           4'h0 : q.port[p].pkt_err) | set_err; // see RULE12

      if (REG_WR && sel[p]) begin
        unique case (REG_ADDR)
          `ADDR_FREQ_CTL:  d.port[p].freq_ctl  = REG_WDATA;
          `ADDR_MAILBOX_A: d.port[p].mailbox_a = REG_WDATA; // see RULE7
          `ADDR_MAILBOX_B: d.port[p].mailbox_b = REG_WDATA; // see RULE7
          default:         d.port[p].mailbox_a = d.port[p].mailbox_a;
        endcase
      end
    end
    if (REG_RD) begin
      d.rdata = read_view(q.port[PORT_SEL], REG_ADDR); // see RULE13
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      q       <= '0;
      for (int p = 0; p < `NUM_RX_PORTS; p++) begin
        q.port[p].freq_ctl  <= `FREQ_CTL_RESET;
        q.port[p].mailbox_a <= `MAILBOX_A_RESET;
        q.port[p].mailbox_b <= `MAILBOX_B_RESET;
        q.port[p].pkt_err   <= `PKT_ERR_RESET;
      end
    end else begin
      q <= d;
    end
  end

  assign REG_RDATA = q.rdata;
  assign HDR_OUT   = ecc_res;

  generate
    for (genvar g = 0; g < `NUM_RX_PORTS; g++) begin : g_out
      assign FREQ_STABLE[g]             = q.port[g].stable;
      assign NO_FORWARD_CLOCK_STATUS[g] = q.port[g].no_clk;
    end
  endgenerate

endmodule
`default_nettype wire

// ==== dv/link_far_side_model.sv ====
// Far-side model of the link: per-port sensor and serializer traffic
`default_nettype none
module link_far_side_model
  import rx_port_video_monitor_pkg::*;
(
  input  wire logic            clk, // Core clock
  output var  video_in_s [3:0] vin  // Traffic per port
);
  initial vin = '0;
  // Fields go inverted after a pulse, so stale data is never reusable
  task automatic send(input int p, input video_in_s v);
    video_in_s r;
    r = ~v;
    r.line_end = 1'b0;
    r.frame_end = 1'b0;
    r.freq_valid = 1'b0;
    r.hdr_valid = 1'b0;
    r.pkt_end = 1'b0;
    @(posedge clk) vin[p] <= v;
    @(posedge clk) vin[p] <= r;
  endtask
endmodule
`default_nettype wire

// ==== dv/rx_port_video_monitor_assertions.sv ====
// Port-level checker for the receive port monitor
`default_nettype none
module rx_port_video_monitor_assertions
  import rx_port_video_monitor_pkg::*;
#(
  parameter logic [13:0] STABLE_LONG_CYCLES = 14'h0028
)
(
  input wire logic            CORE_CLK,  // Clock
  input wire logic            RESET_N,   // Reset, low
  input wire logic [1:0]      PORT_SEL,  // Port
  input wire logic [7:0]      REG_ADDR,  // Offset
  input wire logic [7:0]      REG_WDATA, // Write data
  input wire logic            REG_WR,    // Write
  input wire logic            REG_RD,    // Read
  input wire logic [7:0]      REG_RDATA, // Read data
  input wire logic [3:0]      LINE_LENGTH_CHANGE_IRQ_ENABLE, // Freeze
  input wire video_in_s [3:0] VIDEO_IN,  // Link input
  input wire hdr_out_s [3:0]  HDR_OUT,   // Headers
  input wire logic [3:0]      FREQ_STABLE, // Stable
  input wire logic [3:0]      NO_FORWARD_CLOCK_STATUS // Low clock
);
  localparam int MIN_DWELL = (STABLE_LONG_CYCLES < 14'h0190 ?
    int'(STABLE_LONG_CYCLES) : 400) - 2;
  logic [15:0] low_cnt;
  logic        ev;
  logic        sts_rd;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  assign sts_rd = REG_RD && REG_ADDR == 8'h7A;
  // Any port counts, so a port switch cannot hide a late flag
  always_comb begin
    ev = 1'b0;
    for (int i = 0; i < 4; i++) ev |= VIDEO_IN[i].hdr_valid | VIDEO_IN[i].pkt_end;
  end
  always_ff @(posedge CORE_CLK or negedge RESET_N)
    if (!RESET_N) low_cnt <= '0;
    else if (FREQ_STABLE[1]) low_cnt <= '0;
    else if (low_cnt != 16'hFFFF) low_cnt <= low_cnt + 16'h0001;
  AST_RDATA_HOLD: assert property (!REG_RD |=> $stable(REG_RDATA))
    else $error("read data moved without a read");
  AST_STS_UPPER: assert property (sts_rd |=> REG_RDATA[7:4] == 4'h0)
    else $error("status upper bits not zero");
  AST_STS_CLEAR: assert property (sts_rd && !$past(ev) && !$past(ev, 2) && !ev
    ##1 !REG_RD && !ev ##1 sts_rd && $past(PORT_SEL, 2) == PORT_SEL
    |=> REG_RDATA == 8'h00)
    else $error("status not cleared by read");
  AST_MAILBOX: assert property (REG_WR && REG_ADDR == 8'h78 ##1 !REG_WR && !REG_RD
    ##1 REG_RD && REG_ADDR == 8'h78 && $past(PORT_SEL, 2) == PORT_SEL
    |=> REG_RDATA == $past(REG_WDATA, 3)) else $error("mailbox readback wrong");
  AST_HDR_VALID: assert property (VIDEO_IN[0].hdr_valid |=> HDR_OUT[0].valid
    && !(HDR_OUT[0].single && HDR_OUT[0].multi)) else $error("header result bad");
  AST_HDR_PASS: assert property (HDR_OUT[0].valid && !HDR_OUT[0].single
    |-> HDR_OUT[0].data == $past(VIDEO_IN[0].hdr_data))
    else $error("header altered without single error");
  AST_NOCLK_HOLD: assert property (!VIDEO_IN[1].freq_valid
    |=> $stable(NO_FORWARD_CLOCK_STATUS[1])) else $error("low clock moved");
  AST_STABLE_DWELL: assert property ($rose(FREQ_STABLE[1])
    |-> low_cnt >= 16'(MIN_DWELL)) else $error("stable declared too early");
  cover property (REG_RD && REG_ADDR == 8'h75);
  cover property (HDR_OUT[0].multi);
  cover property ($rose(FREQ_STABLE[1]));
endmodule
`default_nettype wire

// ==== dv/rx_port_video_monitor_tb_top.sv ====
// Self-checking bench for the receive port monitor
`include "rx_port_video_monitor_map.svh"
`default_nettype none
module rx_port_video_monitor_tb_top
  import rx_port_video_monitor_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [13:0] LONG = 14'h0028;
  logic            clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [1:0]      psel = '0;
  logic [7:0]      addr = '0, wdat = '0, rdat;
  logic [3:0]      irq_en = '0, stab, noclk;
  video_in_s [3:0] vin;
  hdr_out_s [3:0]  hout;
  int              num_errors = 0, total_checks = 0, cyc = 0;
  logic [31:0]     seed = 32'h0000F571;
  logic [15:0]     a, b, c, mb [4];
  logic [23:0]     d;
  logic [7:0]      rv [6] = '{8'h00, 8'h00, 8'hC5, 8'h00, 8'h01, 8'h00};
  always #50 clk = ~clk;
  rx_port_video_monitor #(.STABLE_LONG_CYCLES(LONG)) rx_port_video_monitor_i (
    .CORE_CLK(clk), .RESET_N(rst_n), .PORT_SEL(psel), .REG_ADDR(addr),
    .REG_WDATA(wdat), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdat),
    .LINE_LENGTH_CHANGE_IRQ_ENABLE(irq_en), .VIDEO_IN(vin), .HDR_OUT(hout),
    .FREQ_STABLE(stab), .NO_FORWARD_CLOCK_STATUS(noclk));
  link_far_side_model link_far_side_model_i (.clk(clk), .vin(vin));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [5:0] ecc(logic [23:0] x);
    return {^(x & `ECC_MASK_P5), ^(x & `ECC_MASK_P4), ^(x & `ECC_MASK_P3),
            ^(x & `ECC_MASK_P2), ^(x & `ECC_MASK_P1), ^(x & `ECC_MASK_P0)};
  endfunction
  task automatic end_sim();
    if (num_errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(string n, logic [23:0] e, logic [23:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr_reg(logic [1:0] p, logic [7:0] ad, logic [7:0] dt);
    @(posedge clk);
    psel <= p;
    addr <= ad;
    wdat <= dt;
    wr <= 1'b1;
    @(posedge clk) wr <= 1'b0;
  endtask
  task automatic rd_reg(logic [1:0] p, logic [7:0] ad, logic [7:0] e);
    @(posedge clk);
    psel <= p;
    addr <= ad;
    rd <= 1'b1;
    @(posedge clk) rd <= 1'b0;
    #1 chk($sformatf("reg %h", ad), 24'(e), 24'(rdat));
  endtask
  task automatic ln(logic [15:0] l, logic f);
    video_in_s v = '0;
    v.line_end = !f;
    v.frame_end = f;
    v.line_length = l;
    link_far_side_model_i.send(2, v);
  endtask
  task automatic fq(logic [7:0] f);
    video_in_s v = '0;
    v.freq_valid = 1'b1;
    v.freq_mhz = f;
    link_far_side_model_i.send(1, v);
  endtask
  task automatic hd(logic [23:0] x);
    video_in_s v = '0;
    v.hdr_valid = 1'b1;
    v.hdr_data = x;
    v.hdr_ecc = ecc(d);
    link_far_side_model_i.send(0, v);
    #1;
  endtask
  task automatic pk(logic [15:0] n, logic [15:0] cc, logic [15:0] cr);
    video_in_s v = '0;
    v.pkt_end = 1'b1;
    v.pkt_bytes = n;
    v.crc_calc = cc;
    v.crc_rx = cr;
    link_far_side_model_i.send(0, v);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      end_sim();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    for (int p = 0; p < 4; p++)
      for (int i = 0; i < 6; i++) rd_reg(2'(p), 8'h75 + 8'(i), rv[i]);
    rd_reg(2'h0, 8'h7B, 8'h00);
    for (int p = 0; p < 4; p++) begin
      mb[p] = 16'(rnd());
      wr_reg(2'(p), 8'h78, mb[p][7:0]);
      rd_reg(2'(p), 8'h78, mb[p][7:0]);
      wr_reg(2'(p), 8'h79, mb[p][15:8]);
      wr_reg(2'(p), 8'h7A, 8'hFF);
    end
    for (int p = 0; p < 4; p++) begin
      rd_reg(2'(p), 8'h79, mb[p][15:8]);
      rd_reg(2'(p), 8'h7A, 8'h00);
    end
    a = 16'(rnd());
    b = a ^ 16'h5AA5;
    c = ~a;
    ln(a, 1'b0);
    ln(b, 1'b0);
    ln(16'h0000, 1'b1);
    rd_reg(2'h2, 8'h75, b[15:8]);
    rd_reg(2'h2, 8'h76, b[7:0]);
    @(posedge clk) irq_en[2] <= 1'b1;
    ln(a, 1'b0);
    ln(16'h0000, 1'b1);
    ln(c, 1'b0);
    ln(16'h0000, 1'b1);
    rd_reg(2'h2, 8'h75, a[15:8]);
    rd_reg(2'h2, 8'h76, a[7:0]);
    ln(16'h0000, 1'b1);
    rd_reg(2'h2, 8'h75, c[15:8]);
    @(posedge clk) irq_en[2] <= 1'b0;
    ln(b, 1'b0);
    ln(16'h0000, 1'b1);
    rd_reg(2'h2, 8'h75, b[15:8]);
    ln(a, 1'b0);
    ln(16'h0000, 1'b1);
    rd_reg(2'h2, 8'h76, b[7:0]);
    d = {16'(rnd()), 8'h2B};
    hd(d ^ 24'h000100);
    chk("hdr data", d, hout[0].data);
    chk("hdr single", 24'h1, 24'(hout[0].single));
    rd_reg(2'h0, 8'h7A, 8'h01);
    rd_reg(2'h0, 8'h7A, 8'h00);
    hd(d ^ 24'h000300);
    chk("hdr raw", d ^ 24'h000300, hout[0].data);
    pk(d[23:8] + 16'h0001, 16'h1234, 16'h1234);
    rd_reg(2'h0, 8'h7A, 8'h0A);
    pk(d[23:8], 16'h1234, 16'h1235);
    rd_reg(2'h0, 8'h7A, 8'h04);
    pk(d[23:8], 16'h0055, 16'h0055);
    rd_reg(2'h0, 8'h7A, 8'h00);
    fq(8'h03);
    #1 chk("no clock", 24'h1, 24'(noclk[1]));
    fq(8'h14);
    #1 chk("no clock", 24'h0, 24'(noclk[1]));
    repeat (390) @(posedge clk);
    #1 chk("stable", 24'h0, 24'(stab[1]));
    repeat (20) @(posedge clk);
    #1 chk("stable", 24'h1, 24'(stab[1]));
    fq(8'h17);
    repeat (2) @(posedge clk);
    #1 chk("stable", 24'h1, 24'(stab[1]));
    fq(8'h18);
    #1 chk("stable", 24'h0, 24'(stab[1]));
    wr_reg(2'h1, 8'h77, 8'hFF);
    fq(8'h28);
    repeat (30) @(posedge clk);
    #1 chk("stable", 24'h0, 24'(stab[1]));
    repeat (20) @(posedge clk);
    #1 chk("stable", 24'h1, 24'(stab[1]));
    fq(8'h0C);
    #1 chk("no clock", 24'h1, 24'(noclk[1]));
    rd_reg(2'h1, 8'h77, 8'hFF);
    end_sim();
  end
endmodule
bind rx_port_video_monitor rx_port_video_monitor_assertions #(
  .STABLE_LONG_CYCLES(STABLE_LONG_CYCLES)
) rx_port_video_monitor_assertions_i (
  .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .PORT_SEL(PORT_SEL),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
  .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .LINE_LENGTH_CHANGE_IRQ_ENABLE(LINE_LENGTH_CHANGE_IRQ_ENABLE),
  .VIDEO_IN(VIDEO_IN), .HDR_OUT(HDR_OUT), .FREQ_STABLE(FREQ_STABLE),
  .NO_FORWARD_CLOCK_STATUS(NO_FORWARD_CLOCK_STATUS));
`default_nettype wire
